// ===== src/temp_sensor_map.svh
// command codes, bit positions and reset values of the sensor register block
// assumes inclusion by bare name from the sensor design file
`ifndef TEMP_SENSOR_MAP_SVH
`define TEMP_SENSOR_MAP_SVH

`define CMD_LOCAL_TEMP 8'h00
`define CMD_REMOTE_TEMP 8'h01
`define CMD_STATUS 8'h02
`define CMD_CFG_RD 8'h03
`define CMD_LLIM_RD 8'h05
`define CMD_RLIM_RD 8'h07
`define CMD_CFG_WR 8'h09
`define CMD_LLIM_WR 8'h0b
`define CMD_RLIM_WR 8'h0d
`define CMD_ONE_SHOT 8'h0f
`define CMD_REMOTE_FRAC 8'h10
`define CMD_LOCAL_FRAC 8'h11
`define CMD_MAKER_ID 8'hfe

`define CFG_MASK_BIT 7
`define CFG_STANDBY_BIT 6
`define CFG_REMOTE_ONLY_BIT 5
`define CFG_FAULT_QUEUE_BIT 4
`define CFG_WR_MASK 8'hf0

`define ST_BUSY_BIT 7
`define ST_LOCAL_OVER_BIT 6
`define ST_REMOTE_OVER_BIT 4
`define ST_OPEN_BIT 2

`define PTR_RESET 8'h00
`define TEMP_RESET 8'h00
`define CFG_RESET 8'h10
`define LLIM_RESET 8'h46
`define RLIM_RESET 8'h78
`define FAULT_TEMP 8'hff
`define ARA_ADDR 7'h0c
`define BIT_COUNT 4'h8

`endif

// ===== src/temp_sensor_pkg.sv
// types shared by the sensor register block
// assumes nothing beyond a SystemVerilog compiler
package temp_sensor_pkg;

  typedef enum logic [1:0] {
    REQ_PTR = 2'h0,
    REQ_WRITE = 2'h1,
    REQ_READ = 2'h2,
    REQ_ARA = 2'h3
  } req_kind_e;

  typedef struct packed {
    req_kind_e kind;
    logic [7:0] data;
  } link_req_s;

  typedef enum logic [7:0] {
    LS_IDLE = 8'h01,
    LS_ADDR = 8'h02,
    LS_ACK_A = 8'h04,
    LS_CMD = 8'h08,
    LS_ACK_C = 8'h10,
    LS_DATA_W = 8'h20,
    LS_ACK_W = 8'h40,
    LS_READ = 8'h80
  } link_state_e;

  // results in signed quarter degrees, bit 10 is the sign
  typedef struct packed {
    logic [10:0] local_q4;
    logic [10:0] remote_q4;
    logic diode_fault;
  } conv_result_s;

endpackage

// ===== src/temp_sensor_smbus_regs_alert.sv
// smbus byte-register slave of a two-channel temperature sensor with latched alert
// assumes the converter runs on clk_sys and the host drives scl; clk_link oversamples the bus
//
// How it works
// - only write byte, read byte, send byte and receive byte are served
// - receive byte returns the register chosen by the stored pointer
// - local whole degrees at 00h, remote at 01h, one degree per lsb
// - quarter-degree extensions: remote at 10h, local at 11h
// - a finished conversion updates whole and fraction bytes together
// - whole byte is unsigned degrees; negative readings clamp to zero
// - fraction sits in the top two bits, lower six read zero
// - per-channel limit; reading at or above it raises alert unless masked; with fault queue set only the second such reading in a row does
// - reset loads local limit 46h and remote limit 78h
// - diode fault loads ffh into remote byte and sets status bit 2
// - no fault shown after reset until the first conversion ends
// - a diode fault never raises the alert
// - alert latches; clears by status read once no reading is at or above its limit, or by alert response
// - after alert response clear, a reading still at or above its limit re-raises at next conversion
// - alert pin is open drain
// - read codes: status 02h, config 03h, limits 05h and 07h, id feh
// - write codes: config 09h, limits 0bh and 0dh, single shot 0fh
// - config bits: 7 mask, 6 standby, 5 remote only, 4 fault queue
// - status bits: 7 busy, 6 local over, 4 remote over; over bits cleared by read
// - pointer resets to 00h so receive byte returns local temperature
// - single shot ignored in autonomous mode or while one is running
`timescale 1ns/10ps
`include "temp_sensor_map.svh"

module temp_sensor_smbus_regs_alert #(
  parameter logic [6:0] DEV_ADDR = 7'h48,
  // arbitrary identification value
  parameter logic [7:0] MAKER_ID = 8'h5a
) (
  // system side
  input wire logic clk_sys,
  input wire logic rst,
  // bus oversampling clock and bus pins
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // alert pin
  output logic alert_o,
  output logic alert_oe,
  // converter
  input wire logic conv_done,
  input wire temp_sensor_pkg::conv_result_s conv_result,
  input wire logic conv_busy,
  output logic conv_auto,
  output logic conv_single,
  output logic conv_remote_only
);

  // ---------------- link domain ----------------
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [1:0] alert_sync_q;
  logic [2:0] rtog_sync_q;
  logic [7:0] link_rd_q;
  temp_sensor_pkg::link_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic ara_q, ara_d;
  temp_sensor_pkg::link_req_s req_q, req_d;
  logic req_tog_q, req_tog_d;
  // sys-side answer of a read request
  logic [7:0] rd_byte_q;
  logic ack_tog_q;
  logic alert_q;

  // [0] is the first stage and feeds only [1]
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      alert_sync_q <= 2'h0;
      rtog_sync_q <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      alert_sync_q <= {alert_sync_q[0], alert_q};
      rtog_sync_q <= {rtog_sync_q[1:0], ack_tog_q};
    end
  end

  wire scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
  wire scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
  wire bus_start = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
  wire bus_stop = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];
  wire rd_arrived = rtog_sync_q[1] ^ rtog_sync_q[2];
  wire byte_done = (cnt_q == `BIT_COUNT);
  wire addr_hit = (shift_q[7:1] == DEV_ADDR);
  wire ara_hit = (shift_q[7:1] == `ARA_ADDR) & shift_q[0] & alert_sync_q[1];
  // alert response answers with the own address, built locally
  wire [7:0] rd_src = ara_q ? {DEV_ADDR, 1'b0} : link_rd_q;

  // rd_byte_q is held since the request, so it is stable when the toggle lands
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      link_rd_q <= 8'h00;
    end else if (rd_arrived) begin
      link_rd_q <= rd_byte_q;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    oe_d = oe_q;
    rw_d = rw_q;
    ara_d = ara_q;
    req_d = req_q;
    req_tog_d = req_tog_q;
    if (bus_stop) begin
      state_d = temp_sensor_pkg::LS_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      state_d = temp_sensor_pkg::LS_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      shift_d = {shift_q[6:0], sda_sync_q[1]};
      cnt_d = cnt_q + 4'h1;
      // released a one but the line is low: another responder won
      if (state_q == temp_sensor_pkg::LS_READ && !oe_q && !sda_sync_q[1]) begin
        state_d = temp_sensor_pkg::LS_IDLE;
      end
    end else if (scl_fall) begin
      case (state_q)
        temp_sensor_pkg::LS_ADDR: begin
          if (byte_done && (addr_hit || ara_hit)) begin
            oe_d = 1'b1;
            state_d = temp_sensor_pkg::LS_ACK_A;
            rw_d = shift_q[0];
            ara_d = ara_hit;
            if (addr_hit && shift_q[0]) begin
              req_d = '{kind: temp_sensor_pkg::REQ_READ, data: 8'h00};
              req_tog_d = ~req_tog_q;
            end
          end else if (byte_done) begin
            state_d = temp_sensor_pkg::LS_IDLE;
          end
        end
        temp_sensor_pkg::LS_ACK_A: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            state_d = temp_sensor_pkg::LS_READ;
            oe_d = ~rd_src[7];
            tx_d = {rd_src[6:0], 1'b0};
          end else begin
            oe_d = 1'b0;
            state_d = temp_sensor_pkg::LS_CMD;
          end
        end
        temp_sensor_pkg::LS_CMD: begin
          if (byte_done) begin
            oe_d = 1'b1;
            state_d = temp_sensor_pkg::LS_ACK_C;
            req_d = '{kind: temp_sensor_pkg::REQ_PTR, data: shift_q};
            req_tog_d = ~req_tog_q;
          end
        end
        temp_sensor_pkg::LS_ACK_C: begin
          oe_d = 1'b0;
          cnt_d = 4'h0;
          state_d = temp_sensor_pkg::LS_DATA_W;
        end
        temp_sensor_pkg::LS_DATA_W: begin
          if (byte_done) begin
            oe_d = 1'b1;
            state_d = temp_sensor_pkg::LS_ACK_W;
            req_d = '{kind: temp_sensor_pkg::REQ_WRITE, data: shift_q};
            req_tog_d = ~req_tog_q;
          end
        end
        temp_sensor_pkg::LS_ACK_W: begin
          // a second data byte is not a served protocol and gets no ack
          oe_d = 1'b0;
          state_d = temp_sensor_pkg::LS_IDLE;
        end
        temp_sensor_pkg::LS_READ: begin
          if (byte_done) begin
            oe_d = 1'b0;
            state_d = temp_sensor_pkg::LS_IDLE;
            if (ara_q) begin
              req_d = '{kind: temp_sensor_pkg::REQ_ARA, data: 8'h00};
              req_tog_d = ~req_tog_q;
            end
          end else begin
            oe_d = ~tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        default: begin
          state_d = temp_sensor_pkg::LS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      state_q <= temp_sensor_pkg::LS_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      req_q <= '{kind: temp_sensor_pkg::REQ_PTR, data: 8'h00};
      req_tog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      ara_q <= ara_d;
      req_q <= req_d;
      req_tog_q <= req_tog_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;

  // ---------------- system domain ----------------
  logic [2:0] qtog_sync_q;
  logic [7:0] ptr_q;
  logic [7:0] cfg_q;
  logic [7:0] llim_q;
  logic [7:0] rlim_q;
  logic [7:0] ltemp_q;
  logic [7:0] lfrac_q;
  logic [7:0] rtemp_q;
  logic [7:0] rfrac_q;
  logic lover_q;
  logic rover_q;
  logic open_q;
  logic fault_q;
  logic lq_q;
  logic rq_q;
  logic one_shot_q;
  logic single_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qtog_sync_q <= 3'h0;
    end else begin
      qtog_sync_q <= {qtog_sync_q[1:0], req_tog_q};
    end
  end

  // req_q is held by the link until its next request, bytes apart
  wire req_ev = qtog_sync_q[1] ^ qtog_sync_q[2];
  wire ev_ptr = req_ev & (req_q.kind == temp_sensor_pkg::REQ_PTR);
  wire ev_write = req_ev & (req_q.kind == temp_sensor_pkg::REQ_WRITE);
  wire ev_read = req_ev & (req_q.kind == temp_sensor_pkg::REQ_READ);
  wire ev_ara = req_ev & (req_q.kind == temp_sensor_pkg::REQ_ARA);

  wire wr_cfg = ev_write & (ptr_q == `CMD_CFG_WR);
  wire wr_llim = ev_write & (ptr_q == `CMD_LLIM_WR);
  wire wr_rlim = ev_write & (ptr_q == `CMD_RLIM_WR);
  wire wr_shot = ev_write & (ptr_q == `CMD_ONE_SHOT);
  wire rd_status = ev_read & (ptr_q == `CMD_STATUS);

  wire mask = cfg_q[`CFG_MASK_BIT];
  wire standby = cfg_q[`CFG_STANDBY_BIT];
  wire remote_only = cfg_q[`CFG_REMOTE_ONLY_BIT];
  wire fault_queue = cfg_q[`CFG_FAULT_QUEUE_BIT];
  wire shot_ok = wr_shot & standby & ~one_shot_q;

  // new results, clamped and formatted
  wire l_neg = conv_result.local_q4[10];
  wire r_neg = conv_result.remote_q4[10];
  wire r_bad = conv_result.diode_fault;
  wire [7:0] l_whole = l_neg ? `TEMP_RESET : conv_result.local_q4[9:2];
  wire [7:0] l_frac = l_neg ? `TEMP_RESET : {conv_result.local_q4[1:0], 6'h00};
  wire [7:0] r_whole = r_bad ? `FAULT_TEMP : (r_neg ? `TEMP_RESET : conv_result.remote_q4[9:2]);
  wire [7:0] r_frac = (r_bad | r_neg) ? `TEMP_RESET : {conv_result.remote_q4[1:0], 6'h00};
  wire l_update = conv_done & ~remote_only;

  // over at or above the limit; a bad diode never counts as over
  wire l_over_now = l_update & (l_whole >= llim_q);
  wire r_over_now = conv_done & ~r_bad & (r_whole >= rlim_q);
  wire l_trip = l_over_now & (~fault_queue | lq_q);
  wire r_trip = r_over_now & (~fault_queue | rq_q);
  wire alert_set = (l_trip | r_trip) & ~mask;
  // standing condition tracks the limit, so a raised limit lets a read clear
  wire l_cond = ~remote_only & (ltemp_q >= llim_q);
  wire r_cond = ~fault_q & (rtemp_q >= rlim_q);
  wire alert_clr = (rd_status & ~l_cond & ~r_cond) | ev_ara;

  wire [7:0] status_byte = {conv_busy, lover_q, 1'b0, rover_q, 1'b0, open_q, 2'h0};
  wire [7:0] rd_mux =
    (ptr_q == `CMD_LOCAL_TEMP) ? ltemp_q :
    (ptr_q == `CMD_REMOTE_TEMP) ? rtemp_q :
    (ptr_q == `CMD_STATUS) ? status_byte :
    (ptr_q == `CMD_CFG_RD) ? cfg_q :
    (ptr_q == `CMD_LLIM_RD) ? llim_q :
    (ptr_q == `CMD_RLIM_RD) ? rlim_q :
    (ptr_q == `CMD_REMOTE_FRAC) ? rfrac_q :
    (ptr_q == `CMD_LOCAL_FRAC) ? lfrac_q :
    (ptr_q == `CMD_MAKER_ID) ? MAKER_ID : 8'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptr_q <= `PTR_RESET;
      cfg_q <= `CFG_RESET;
      llim_q <= `LLIM_RESET;
      rlim_q <= `RLIM_RESET;
    end else begin
      if (ev_ptr) ptr_q <= req_q.data;
      // other codes fall through untouched
      if (wr_cfg) cfg_q <= req_q.data & `CFG_WR_MASK;
      if (wr_llim) llim_q <= req_q.data;
      if (wr_rlim) rlim_q <= req_q.data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ltemp_q <= `TEMP_RESET;
      lfrac_q <= `TEMP_RESET;
      rtemp_q <= `TEMP_RESET;
      rfrac_q <= `TEMP_RESET;
      fault_q <= 1'b0;
      lq_q <= 1'b0;
      rq_q <= 1'b0;
    end else if (conv_done) begin
      if (l_update) begin
        ltemp_q <= l_whole;
        lfrac_q <= l_frac;
        lq_q <= l_over_now;
      end
      rtemp_q <= r_whole;
      rfrac_q <= r_frac;
      fault_q <= r_bad;
      rq_q <= r_over_now;
    end
  end

  // set wins over a clearing read landing in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lover_q <= 1'b0;
      rover_q <= 1'b0;
      open_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      lover_q <= l_over_now | (lover_q & ~rd_status);
      rover_q <= r_over_now | (rover_q & ~rd_status);
      open_q <= (conv_done & r_bad) | (open_q & ~(rd_status & ~fault_q));
      alert_q <= alert_set | (alert_q & ~alert_clr);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      one_shot_q <= 1'b0;
      single_q <= 1'b0;
      rd_byte_q <= 8'h00;
      ack_tog_q <= 1'b0;
    end else begin
      one_shot_q <= shot_ok | (one_shot_q & ~conv_done);
      single_q <= shot_ok;
      if (ev_read) begin
        rd_byte_q <= rd_mux;
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = alert_q;
  assign conv_auto = ~standby;
  assign conv_single = single_q;
  assign conv_remote_only = remote_only;

endmodule

// ===== verif/smbus_host_model.sv
// smbus host model: bit-banged byte transfers on an open-drain data line
// assumes the bench resolves sda from host_low and the device enable
`timescale 1ns/10ps
module smbus_host_model (
  // bus pins
  output logic scl,
  output logic host_low,
  input wire logic sda,
  // last read byte
  output logic [7:0] rx,
  output logic rx_stb
);
  localparam time Q = 250ns;
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
    rx = 8'h00;
    rx_stb = 1'b0;
  end
  // scl stands high between frames; sda is released unless a 0 is sent
  task automatic bit_io(input logic b, input time hi, output logic r);
    #Q host_low = ~b;
    #Q scl = 1'b1;
    #hi r = sda;
    scl = 1'b0;
  endtask
  // long ack clock gives the read fetch time to cross domains
  task automatic wbyte(input logic [7:0] d, input time ack_hi, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], Q, r);
    bit_io(1'b1, ack_hi, r);
    ack = ~r;
  endtask
  task automatic rbyte;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, Q, r);
      rx[i] = r;
    end
    rx_stb = 1'b1;
    #10 rx_stb = 1'b0;
    bit_io(1'b1, Q, r);
  endtask
  task automatic start;
    #Q host_low = 1'b0;
    #Q scl = 1'b1;
    #Q host_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop;
    #Q host_low = 1'b1;
    #Q scl = 1'b1;
    #Q host_low = 1'b0;
    #Q;
  endtask
  // nw: bytes after the address (0 receive, 1 send, 2 write); rd adds a read phase
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                      input int nw, input logic rd, output logic ok);
    logic k;
    ok = 1'b1;
    start();
    if (nw > 0) begin
      wbyte({a, 1'b0}, Q, k);
      ok &= k;
      wbyte(c, Q, k);
      ok &= k;
      if (nw > 1) begin
        wbyte(d, Q, k);
        ok &= k;
      end
      if (rd) start();
    end
    if (rd) begin
      wbyte({a, 1'b1}, 2us, k);
      ok &= k;
      rbyte();
    end
    stop();
  endtask
endmodule

// ===== verif/temp_sensor_smbus_regs_alert_chk.sv
// port assertions of the sensor register block
// assumes binding into every instance of the block
`timescale 1ns/10ps
module temp_sensor_smbus_regs_alert_chk (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_link,
  // pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alert_o,
  input wire logic alert_oe,
  // converter
  input wire logic conv_done,
  input wire logic conv_auto,
  input wire logic conv_single,
  input wire logic conv_remote_only
);
  logic scl_q;
  logic shot_q;
  logic [9:0] quiet_q;
  // bus quiet time: alert may only fall and config only move while the host is clocking
  wire scl_edge = scl_i ^ scl_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      shot_q <= 1'b0;
      quiet_q <= 10'h000;
    end else begin
      scl_q <= scl_i;
      shot_q <= conv_single | (shot_q & ~conv_done);
      quiet_q <= scl_edge ? 10'h000 : quiet_q + {9'h000, ~&quiet_q};
    end
  end
  sequence s_pulse;
    conv_single ##1 !conv_single;
  endsequence
  property p_open_drain;
    @(posedge clk_sys) disable iff (rst) !sda_o && !alert_o;
  endproperty
  property p_alert_cause;
    @(posedge clk_sys) disable iff (rst) $rose(alert_oe) |-> $past(conv_done) || $past(conv_done, 2);
  endproperty
  property p_alert_hold;
    @(posedge clk_sys) disable iff (rst) $fell(alert_oe) |-> quiet_q < 10'h0fa;
  endproperty
  property p_shot_mode;
    @(posedge clk_sys) disable iff (rst) conv_single |-> !conv_auto;
  endproperty
  property p_shot_once;
    @(posedge clk_sys) disable iff (rst) conv_single |-> !shot_q;
  endproperty
  property p_shot_pulse;
    @(posedge clk_sys) disable iff (rst) conv_single |-> s_pulse;
  endproperty
  property p_cfg_bus;
    @(posedge clk_sys) disable iff (rst) $changed({conv_auto, conv_remote_only}) |-> quiet_q < 10'h0fa;
  endproperty
  property p_sda_step;
    @(posedge clk_link) disable iff (rst) $changed(sda_oe) |-> !scl_i;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");
  a_alert_cause: assert property (p_alert_cause) else $error("alert rose without conversion");
  a_alert_hold: assert property (p_alert_hold) else $error("alert fell without bus access");
  a_shot_mode: assert property (p_shot_mode) else $error("single shot in autonomous mode");
  a_shot_once: assert property (p_shot_once) else $error("single shot while one runs");
  a_shot_pulse: assert property (p_shot_pulse) else $error("single shot not one cycle");
  a_cfg_bus: assert property (p_cfg_bus) else $error("config changed without write");
  a_sda_step: assert property (p_sda_step) else $error("sda moved while scl high");
endmodule

bind temp_sensor_smbus_regs_alert temp_sensor_smbus_regs_alert_chk chk_i (.clk_sys(clk_sys), .rst(rst),
  .clk_link(clk_link), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
  .alert_oe(alert_oe), .conv_done(conv_done), .conv_auto(conv_auto), .conv_single(conv_single),
  .conv_remote_only(conv_remote_only));

// ===== verif/temp_sensor_smbus_regs_alert_tb.sv
// self-checking bench of the sensor register block with an smbus host model
// assumes the host model and the checker bind are compiled with it
`timescale 1ns/10ps
module temp_sensor_smbus_regs_alert_tb;
  localparam logic [6:0] ADDR = 7'h48;
  // arbitrary identification value
  localparam logic [7:0] ID = 8'h3c;
  localparam logic [7:0] RC [5] = '{8'h02, 8'h03, 8'h05, 8'h07, 8'hfe};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h10, 8'h46, 8'h78, ID};
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic conv_done = 1'b0;
  logic conv_busy = 1'b0;
  logic scl, host_low, sda, sda_o, sda_oe, alert_o, alert_oe, rx_stb, ok;
  logic conv_auto, conv_single, conv_remote_only;
  temp_sensor_pkg::conv_result_s conv_result = '0;
  logic [7:0] rx;
  logic [10:0] rq;
  logic [15:0] nt;
  logic [15:0] exp_q[$];
  logic [31:0] rnd = 32'h0000_b9cb;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int shots = 0;
  always #4 clk_sys = ~clk_sys;
  always #62.5 clk_link = ~clk_link;
  // pulled-up wired data line
  assign sda = ~(sda_oe | host_low);
  temp_sensor_smbus_regs_alert #(.DEV_ADDR(ADDR), .MAKER_ID(ID)) uut (.clk_sys(clk_sys), .rst(rst),
    .clk_link(clk_link), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .conv_done(conv_done), .conv_result(conv_result), .conv_busy(conv_busy),
    .conv_auto(conv_auto), .conv_single(conv_single), .conv_remote_only(conv_remote_only));
  smbus_host_model host (.scl(scl), .host_low(host_low), .sda(sda), .rx(rx), .rx_stb(rx_stb));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    n_checks++;
    if (got !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic complete_run;
    // a read note left unanswered also fails the run
    if (fails == 0 && n_checks > 0 && exp_q.size() == 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // nw 1 read byte, nw 0 receive byte; the note carries a mask for undefined bits
  task automatic rd(input logic [7:0] c, input int nw, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    host.xfer(ADDR, c, 8'h00, nw, 1'b1, ok);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host.xfer(ADDR, c, d, 2, 1'b0, ok);
  endtask
  task automatic conv(input logic [10:0] lq, input logic [10:0] r, input logic f);
    @(posedge clk_sys);
    conv_result <= '{lq, r, f};
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) begin
      chk(rx, ~rx);
    end else begin
      nt = exp_q.pop_front();
      chk(rx & nt[15:8], nt[7:0]);
    end
  end
  // run ceiling about an eighth above the expected length of the sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (conv_single === 1'b1) shots++;
    if (cyc == 100000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk_link);
    rst <= 1'b0;
    repeat (4) @(posedge clk_link);
    rd(8'h00, 0, 8'hff, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(RC[i], 1, 8'hff, RV[i]);
    end
    rnd = xs(rnd);
    rq = 11'(rnd % 480);
    conv(11'h209, rq, 1'b0);
    chk({7'h00, alert_oe}, 8'h00);
    rd(8'h00, 1, 8'hff, 8'h82);
    rd(8'h11, 1, 8'hc0, 8'h40);
    rd(8'h01, 1, 8'hff, rq[9:2]);
    rd(8'h10, 1, 8'hc0, {rq[1:0], 6'h00});
    conv(11'h209, rq, 1'b0);
    chk({7'h00, alert_oe}, 8'h01);
    // alert response: the device names itself, then the latch drops
    exp_q.push_back({8'hff, ADDR, 1'b0});
    host.xfer(7'h0c, 8'h00, 8'h00, 0, 1'b1, ok);
    chk({7'h00, alert_oe}, 8'h00);
    // condition still there: next conversion raises it again
    conv(11'h209, rq, 1'b0);
    chk({7'h00, alert_oe}, 8'h01);
    conv_busy <= 1'b1;
    rd(8'h02, 1, 8'hff, 8'hc0);
    @(posedge clk_sys) conv_busy <= 1'b0;
    chk({7'h00, alert_oe}, 8'h01);
    wr(8'h0b, 8'hff);
    chk({7'h00, ok}, 8'h01);
    rd(8'h02, 1, 8'hff, 8'h00);
    chk({7'h00, alert_oe}, 8'h00);
    // two faulty conversions, so the fault queue cannot hide a wrong alert
    repeat (2) conv(11'h7ec, 11'h000, 1'b1);
    chk({7'h00, alert_oe}, 8'h00);
    rd(8'h00, 1, 8'hff, 8'h00);
    rd(8'h01, 1, 8'hff, 8'hff);
    rd(8'h02, 1, 8'h04, 8'h04);
    rnd = xs(rnd);
    wr(8'h00, rnd[7:0]);
    rd(8'h05, 1, 8'hff, 8'hff);
    wr(8'h0f, 8'h00);
    chk(8'(shots), 8'h00);
    host.xfer(ADDR, 8'h03, 8'h00, 1, 1'b0, ok);
    rd(8'h00, 0, 8'hff, 8'h10);
    wr(8'h09, 8'he0);
    chk({6'h00, conv_auto, conv_remote_only}, 8'h01);
    conv(11'h000, 11'h258, 1'b0);
    chk({7'h00, alert_oe}, 8'h00);
    rd(8'h02, 1, 8'hff, 8'h14);
    // second trigger lands while the first is still running
    repeat (2) wr(8'h0f, 8'h00);
    chk(8'(shots), 8'h01);
    complete_run();
  end
endmodule
